// *** design/gpio_ctl_if.sv ***
// interface carrying per-pin controls from the register file to the pad logic
`default_nettype none
interface gpio_ctl_if;
    import gpio_port_pkg::*;
    port_vec_t latch;     // data latch
    port_vec_t dir;       // direction
    port_vec_t ain_dis;   // analog input disable
    logic standby_float;  // standby float request
    port_vec_t pin_in;    // conditioned digital input
    modport regs (output latch, output dir, output ain_dis, output standby_float,
                  input pin_in);
    modport pads (input latch, input dir, input ain_dis, input standby_float,
                  output pin_in);
endinterface : gpio_ctl_if
`default_nettype wire

// *** design/gpio_pad_slice.sv ***
// per-pin pad logic: output mux, enable and input gating
`default_nettype none
module gpio_pad_slice
    import gpio_port_pkg::*;
(
    gpio_ctl_if.pads ctl,                         // controls from register file
    input wire gpio_port_pkg::port_vec_t pad_in,  // pin levels
    input wire gpio_port_pkg::port_vec_t per_oe,  // peripheral output enables
    input wire gpio_port_pkg::port_vec_t per_out, // peripheral output values
    input wire gpio_port_pkg::port_vec_t irq_en,  // external interrupt enables
    output logic [7:0] pad_out,                   // pin drive value
    output logic [7:0] pad_oe                     // pin drive enable
);
    genvar n;
    // per-bit results gather on nets, so each variable keeps a single driver
    wire [7:0] out_w; // per-pin drive value
    wire [7:0] oe_w;  // per-pin drive enable
    wire [7:0] in_w;  // per-pin conditioned input
    // one slice per pin, bit n serves pin n
    generate
        for (n = 0; n < PORT_WIDTH; n++) begin : g_pin
            wire drive_port = ctl.dir[n];
            wire drive_any = drive_port | per_oe[n];
            // peripheral wins the pin over the latch
            assign out_w[n] = per_oe[n] ? per_out[n] : ctl.latch[n];
            // float in standby when requested, otherwise hold state
            assign oe_w[n] = drive_any & ~ctl.standby_float;
            // input blocked (forced low) in float standby unless irq open
            wire blocked = ctl.standby_float & ~irq_en[n];
            // digital input needs disable bit set; analog pins stay quiet
            assign in_w[n] = pad_in[n] & ctl.ain_dis[n] & ~blocked;
        end
    endgenerate
    assign pad_out = out_w;
    assign pad_oe = oe_w;
    assign ctl.pin_in = in_w;
endmodule : gpio_pad_slice
`default_nettype wire

// *** design/gpio_port_pkg.sv ***
// constants and rule summary for the port zero gpio block
// Function
// - direction bit one makes pin output
// - output pin driven from data latch
// - latch write reaches output pins directly
// - direction bit zero makes pin input
// - latch write on input pin stored only
// - normal read of output bits returns latch
// - input bits read pin, rmw reads latch
// - peripheral output enable overrides latch on pin
// - peripheral driven pin reads pin level
// - disable bit one enables digital input
// - reset clears direction and disable registers
// - standby with bit set floats pins, blocks input
// - enabled interrupt input stays open in standby
// - standby with bit clear keeps pin state
// - pin level always goes to interrupt circuit; code blocks pins without irq enable in float standby
`default_nettype none
package gpio_port_pkg;
    localparam int PORT_WIDTH = 8;                  // pins in the port
    localparam int ADDR_WIDTH = 4;                  // register address width
    typedef logic [PORT_WIDTH-1:0] port_vec_t;      // one bit per pin
    typedef logic [ADDR_WIDTH-1:0] reg_addr_t;      // register address
    localparam reg_addr_t DATA_LATCH_ADDR = 4'h0;   // port_zero_data_latch
    localparam reg_addr_t DIRECTION_ADDR = 4'h1;    // port_zero_direction
    localparam reg_addr_t ANALOG_DIS_ADDR = 4'h2;   // analog_input_disable_low
    localparam reg_addr_t STANDBY_ADDR = 4'h3;      // standby_control_reg
    localparam int STANDBY_PIN_BIT = 0;             // standby_pin_state_bit position
    localparam port_vec_t DATA_LATCH_RESET = 8'h00; // latch reset value
    localparam port_vec_t DIRECTION_RESET = 8'h00;  // direction reset value
    localparam port_vec_t ANALOG_DIS_RESET = 8'h00; // analog disable reset value
    localparam port_vec_t STANDBY_RESET = 8'h00;    // standby control reset value
    localparam port_vec_t READ_ZERO = 8'h00;        // unmapped read value
endpackage : gpio_port_pkg
`default_nettype wire

// *** design/gpio_port_zero.sv ***
// port zero gpio top: register file, read mux and pad logic
//
// Our own choices: the strobed register port and the register offsets.
`default_nettype none
module gpio_port_zero
    import gpio_port_pkg::*;
(
    input wire logic clk,                          // 250 MHz clock
    input wire logic rst,                          // async reset, high
    input wire gpio_port_pkg::reg_addr_t addr,     // register address
    input wire gpio_port_pkg::port_vec_t wdata,    // write data
    input wire logic wr,                           // write strobe
    input wire logic rd,                           // read strobe
    input wire logic rd_rmw,                       // read belongs to rmw op
    output gpio_port_pkg::port_vec_t rdata,        // read data, cycle after rd
    input wire logic standby_enter,                // stop or watch mode active
    input wire gpio_port_pkg::port_vec_t pad_in,   // pin levels
    output logic [7:0] pad_out,                    // pin drive value
    output logic [7:0] pad_oe,                     // pin drive enable
    input wire gpio_port_pkg::port_vec_t per_oe,   // peripheral output enables
    input wire gpio_port_pkg::port_vec_t per_out,  // peripheral outputs
    input wire gpio_port_pkg::port_vec_t irq_en,   // external irq enables
    output gpio_port_pkg::port_vec_t irq_pin,      // level to irq circuit
    output gpio_port_pkg::port_vec_t digital_in    // conditioned digital inputs
);
    import gpio_port_pkg::*;

    gpio_ctl_if ctl ();                 // control bundle

    port_vec_t latch_q;                 // data latch
    port_vec_t dir_q;                   // direction register
    port_vec_t ain_dis_q;               // analog input disable register
    port_vec_t standby_q;               // standby control register
    port_vec_t rdata_q;                 // read data register

    // write decodes
    wire wr_latch = wr && (addr == DATA_LATCH_ADDR);
    wire wr_dir = wr && (addr == DIRECTION_ADDR);
    wire wr_ain = wr && (addr == ANALOG_DIS_ADDR);
    wire wr_stby = wr && (addr == STANDBY_ADDR);

    // float only when the pin-state bit is set and standby is entered
    wire standby_float = standby_q[STANDBY_PIN_BIT] & standby_enter;

    assign ctl.latch = latch_q;
    assign ctl.dir = dir_q;
    assign ctl.ain_dis = ain_dis_q;
    assign ctl.standby_float = standby_float;

    // pin view for normal reads: latch where port drives, pin elsewhere
    wire port_vec_t normal_view = (dir_q & ~per_oe & latch_q) |
                                  (~(dir_q & ~per_oe) & ctl.pin_in);
    // rmw reads always see the latch
    wire port_vec_t data_view = rd_rmw ? latch_q : normal_view;

    // read mux, unmapped addresses read zero
    wire port_vec_t rdata_d = (addr == DATA_LATCH_ADDR) ? data_view :
                              (addr == DIRECTION_ADDR) ? dir_q :
                              (addr == ANALOG_DIS_ADDR) ? ain_dis_q :
                              (addr == STANDBY_ADDR) ? standby_q : READ_ZERO;

    // data latch: stored on every write, whatever the direction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_q <= DATA_LATCH_RESET;
        end else if (wr_latch) begin
            latch_q <= wdata;
        end
    end

    // direction and analog disable, cleared by reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_q <= DIRECTION_RESET;
            ain_dis_q <= ANALOG_DIS_RESET;
        end else begin
            if (wr_dir) begin
                dir_q <= wdata;
            end
            if (wr_ain) begin
                ain_dis_q <= wdata;
            end
        end
    end

    // standby control register, only the pin-state bit is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            standby_q <= STANDBY_RESET;
        end else if (wr_stby) begin
            standby_q <= wdata & (8'h01 << STANDBY_PIN_BIT);
        end
    end

    // read data: valid the cycle after rd only, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= READ_ZERO;
        end else begin
            rdata_q <= rd ? rdata_d : READ_ZERO;
        end
    end

    assign rdata = rdata_q;
    // pin level goes straight to the irq circuit, gated only by standby block
    assign irq_pin = pad_in & ~({PORT_WIDTH{standby_float}} & ~irq_en);
    assign digital_in = ctl.pin_in;

    gpio_pad_slice u_pads (
        .ctl(ctl.pads),
        .pad_in(pad_in),
        .per_oe(per_oe),
        .per_out(per_out),
        .irq_en(irq_en),
        .pad_out(pad_out),
        .pad_oe(pad_oe)
    );

    // direction one with no peripheral drives the latch out next cycle, except in float standby
    a_port_drive: assert property (@(posedge clk) disable iff (rst)
        (pad_oe == ((dir_q | per_oe) & {PORT_WIDTH{~standby_float}})))
        else $error("pin enable mismatch");
    a_latch_out: assert property (@(posedge clk) disable iff (rst)
        wr_latch |=> ((pad_out & ~per_oe) == (latch_q & ~per_oe)) && latch_q == $past(wdata))
        else $error("latch not on pins");
    a_reset_clear: assert property (@(posedge clk) $fell(rst) |-> dir_q == 8'h00 && ain_dis_q == 8'h00)
        else $error("reset values wrong");
    a_rmw_read: assert property (@(posedge clk) disable iff (rst)
        (rd && rd_rmw && addr == DATA_LATCH_ADDR) |=> rdata == $past(latch_q))
        else $error("rmw read not latch");
    a_float_stby: assert property (@(posedge clk) disable iff (rst)
        standby_float |-> pad_oe == 8'h00 && (ctl.pin_in & ~irq_en) == 8'h00)
        else $error("standby not floating");
    a_keep_stby: assert property (@(posedge clk) disable iff (rst)
        !standby_q[STANDBY_PIN_BIT] |-> pad_oe == (dir_q | per_oe))
        else $error("standby changed pins");
    a_analog_gate: assert property (@(posedge clk) disable iff (rst)
        (ctl.pin_in & ~ain_dis_q) == 8'h00)
        else $error("analog pin gave input");
    a_periph_pin: assert property (@(posedge clk) disable iff (rst)
        (per_oe & pad_out) == (per_oe & per_out))
        else $error("peripheral not routed");
endmodule : gpio_port_zero
`default_nettype wire

// *** tb/pin_world.sv ***
// model of the pins and outside world of port zero
`default_nettype none
module pin_world (
    input wire logic [7:0] pad_out, // pin drive value
    input wire logic [7:0] pad_oe,  // pin drive enable
    input wire logic [7:0] ext_lvl, // level held by the outside
    output logic [7:0] pad_in       // resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driven pin shows its driver, a floating one the outside level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : pin_world
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the port zero gpio block
`default_nettype none
module testbench;
    import gpio_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, rd_rmw = 1'h0, standby_enter = 1'h0;
    reg_addr_t addr = 4'h0; // register address
    port_vec_t wdata = 8'h00, per_oe = 8'h00, per_out = 8'h00, irq_en = 8'h00;
    port_vec_t ext_lvl = 8'hC3; // outside level, mixed so bit order shows
    port_vec_t rdata, pad_in, irq_pin, digital_in;
    logic [7:0] pad_out, pad_oe;
    int num_errors = 0, total_checks = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    gpio_port_zero gpio_port_zero_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rd_rmw(rd_rmw), .rdata(rdata), .standby_enter(standby_enter),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .per_oe(per_oe),
        .per_out(per_out), .irq_en(irq_en), .irq_pin(irq_pin), .digital_in(digital_in));
    pin_world pin_world_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl),
        .pad_in(pad_in));
    task check(string name, port_vec_t exp, port_vec_t got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // one-cycle write strobe, pins settle before return
    task wr_reg(reg_addr_t a, port_vec_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe, so sample there
    task rd_chk(string name, reg_addr_t a, logic rmw, port_vec_t exp);
        @(posedge clk);
        addr <= a;
        rd_rmw <= rmw;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        rd_rmw <= 1'h0;
        #1;
        check(name, exp, rdata);
    endtask : rd_chk
    task t_reset;
        wr_reg(4'hF, 8'hFF);
        rd_chk("unmapped", 4'hF, 1'h0, READ_ZERO);
        rd_chk("direction", DIRECTION_ADDR, 1'h0, DIRECTION_RESET);
        rd_chk("analog_dis", ANALOG_DIS_ADDR, 1'h0, ANALOG_DIS_RESET);
        check("digital_in", 8'h00, digital_in);
        check("pad_oe", 8'h00, pad_oe);
    endtask : t_reset
    task t_output;
        wr_reg(DIRECTION_ADDR, 8'hFF);
        wr_reg(DATA_LATCH_ADDR, 8'hA5);
        check("pad_oe", 8'hFF, pad_oe);
        check("pad_out", 8'hA5, pad_out);
        rd_chk("latch_read", DATA_LATCH_ADDR, 1'h0, 8'hA5);
    endtask : t_output
    task t_input;
        wr_reg(ANALOG_DIS_ADDR, 8'hFF);
        wr_reg(DIRECTION_ADDR, 8'h0F);
        wr_reg(DATA_LATCH_ADDR, 8'h5A);
        check("pad_oe", 8'h0F, pad_oe);
        check("pad_out_low", 8'h0A, pad_out & 8'h0F);
        rd_chk("pin_read", DATA_LATCH_ADDR, 1'h0, 8'hCA);
        rd_chk("rmw_read", DATA_LATCH_ADDR, 1'h1, 8'h5A);
        wr_reg(ANALOG_DIS_ADDR, 8'h3F);
        check("digital_in", 8'h0A, digital_in);
        rd_chk("gated_read", DATA_LATCH_ADDR, 1'h0, 8'h0A);
    endtask : t_input
    task t_periph;
        wr_reg(ANALOG_DIS_ADDR, 8'hFF);
        wr_reg(DIRECTION_ADDR, 8'hFF);
        wr_reg(DATA_LATCH_ADDR, 8'h00);
        @(posedge clk);
        per_oe <= 8'hF0;
        per_out <= 8'hA0;
        @(posedge clk);
        #1;
        check("pad_out", 8'hA0, pad_out);
        check("pad_oe", 8'hFF, pad_oe);
        rd_chk("per_read", DATA_LATCH_ADDR, 1'h0, 8'hA0);
        rd_chk("per_rmw", DATA_LATCH_ADDR, 1'h1, 8'h00);
    endtask : t_periph
    task t_standby;
        @(posedge clk);
        per_oe <= 8'h00;
        irq_en <= 8'h01;
        standby_enter <= 1'h1;
        wr_reg(STANDBY_ADDR, 8'h01);
        check("pad_oe", 8'h00, pad_oe);
        check("digital_in", 8'h01, digital_in);
        check("irq_pin", 8'h01, irq_pin);
        wr_reg(DATA_LATCH_ADDR, 8'h3C);
        wr_reg(STANDBY_ADDR, 8'h00);
        check("pad_oe", 8'hFF, pad_oe);
        check("irq_pin", 8'h3C, irq_pin);
    endtask : t_standby
    task stop_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // main sequence: reset for five cycles, then each scenario in turn
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_output();
        t_input();
        t_periph();
        t_standby();
        stop_test();
    end
    // watchdog: the whole run needs well under a microsecond
    initial begin
        #20000;
        num_errors++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
